// >>> hdl/serial_link_tx_control.sv
// serial link transmit control: register bank, sample fifo and link word generator
//
// Functional notes
// - frames per multiframe is five unless control bit selects the length register.
// - transport test bit replaces samples with a test pattern.
// - flip bit reverses output word bit order; clear keeps normal order.
// - lane marker bit inserts K28.3 at multiframe end.
// - frame marker bit inserts K28.7 at frame end.
// - alignment-off bit skips the alignment sequence after sync release.
// - sync source select picks software sync bit instead of the sync pin.
// - software sync with register sourcing sends only K28.5 characters.
// - lane-mode field resets to 001; software keeps serializer setting consistent.
// - bypass filter gives eight lanes for mode 001, four for 100 or 010.
// - 2X filter gives four lanes for mode 001, two for 010.
// - complex 4X filter gives four lanes for mode 001, two for 010.
// - link pattern field picks data, D21.5, K28.5, repeated alignment or RPAT.
// - multiframe clock reset requests are ignored while the mask bit is set.
`default_nettype none

module sample_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [PW:0]                 cnt;
    logic                        full;
    logic                        empty;
  } fifo_t;
  fifo_t q;
  fifo_t next_q;
  logic  push;
  logic  pop;
  assign in_ready  = ~q.full;
  assign out_valid = ~q.empty;
  assign out_data  = q.mem[q.rd];
  // flags are kept registered so the ready seen upstream never glitches
  always_comb begin
    next_q = q;
    push   = in_valid & ~q.full;
    pop    = out_ready & ~q.empty;
    if (push) begin
      next_q.mem[q.wr] = in_data;
      next_q.wr        = q.wr + PW'(1);
    end
    if (pop) begin
      next_q.rd = q.rd + PW'(1);
    end
    next_q.cnt   = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
    next_q.full  = (next_q.cnt == FULL_CNT);
    next_q.empty = (next_q.cnt == '0);
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '{mem: '0, wr: '0, rd: '0, cnt: '0, full: 1'b0, empty: 1'b1};
    end else begin
      q <= next_q;
    end
  end
endmodule : sample_fifo

module serial_link_tx_control (
  input  wire logic                               clk,
  input  wire logic                               srst,
  input  wire logic [tx_link_pkg::ADDR_W-1:0]     address,
  input  wire logic                               read,
  input  wire logic                               write,
  input  wire logic [31:0]                        writedata,
  input  wire logic [3:0]                         byteenable,
  output logic [31:0]                             readdata,
  output logic                                    waitrequest,
  input  wire logic [tx_link_pkg::DATA_W-1:0]     sample_data,
  input  wire logic                               sample_valid,
  output logic                                    sample_ready,
  input  wire logic                               sync_n,
  input  wire logic                               lmfc_reset_req,
  output logic [tx_link_pkg::DATA_W-1:0]          lane_data,
  output logic [1:0]                              lane_k,
  output logic                                    lane_valid,
  input  wire logic                               lane_ready,
  output logic [7:0]                              lane_enable
);
  import tx_link_pkg::*;
  typedef struct packed {
    logic              waitrequest;
    logic [31:0]       rdata;
    logic [7:0]        framing;
    logic [7:0]        sync_lane;
    logic [7:0]        test_lmfc;
    logic [4:0]        frames;
    logic              sync_meta;
    logic              sync_s;
    logic              lmfc_meta;
    logic              lmfc_s;
    logic              lmfc_prev;
    link_state_t       st;
    logic [5:0]        frame;
    logic [1:0]        mf;
    logic [3:0]        rp;
    logic              out_valid;
    logic [DATA_W-1:0] out_data;
    logic [1:0]        out_k;
    logic [7:0]        lanes;
  } top_t;
  localparam top_t Q_RST = '{
    waitrequest: 1'b1, rdata: '0, framing: RST_FRAMING, sync_lane: RST_SYNC,
    test_lmfc: RST_TEST, frames: RST_FRAMES, sync_meta: 1'b1, sync_s: 1'b1,
    lmfc_meta: 1'b0, lmfc_s: 1'b0, lmfc_prev: 1'b0, st: ST_SYNC, frame: '0,
    mf: '0, rp: '0, out_valid: 1'b0, out_data: '0, out_k: '0, lanes: '0};
  top_t              q;
  top_t              next_q;
  logic [DATA_W-1:0] fifo_data;
  logic              fifo_valid;
  logic              pop;
  logic              sync_req;
  logic [5:0]        k_len;
  logic              last_frame;
  logic              lmfc_hit;
  logic              adv;
  logic [2:0]        idx;
  link_pat_t         pat;
  logic [DATA_W-1:0] fifo_rev;
  // lane count per filter and mode pair; unlisted pairs leave every lane off
  function automatic logic [7:0] lanes_for(input logic [2:0] filt, input logic [2:0] mode);
    logic [7:0] l;
    l = 8'h00;
    unique case (filt)
      FILT_BYPASS: begin
        if (mode == MODE_1) l = 8'hFF;
        else if (mode == MODE_2 || mode == MODE_4) l = 8'h0F;
      end
      FILT_2X, FILT_4X_IQ: begin
        if (mode == MODE_1) l = 8'h0F;
        else if (mode == MODE_2) l = 8'h03;
      end
      FILT_4X: begin
        if (mode == MODE_1) l = 8'h03;
        else if (mode == MODE_2) l = 8'h01;
      end
      default: l = 8'h00;
    endcase
    return l;
  endfunction : lanes_for
  sample_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_data   (sample_data),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (pop)
  );
  assign waitrequest = q.waitrequest;
  assign readdata    = q.rdata;
  assign lane_data   = q.out_data;
  assign lane_k      = q.out_k;
  assign lane_valid  = q.out_valid;
  assign lane_enable = q.lanes;
  // shared decode terms
  assign idx      = address[4:2];
  assign pat      = link_pat_t'(q.test_lmfc[F_LINK_LO +: 3]);
  assign sync_req = q.sync_lane[B_SYNC_SEL] ? q.sync_lane[B_SYNC_SW] : ~q.sync_s;
  assign k_len    = q.framing[B_CTRL_K] ? ({1'b0, q.frames} + 6'h01) : K_DEFAULT;
  assign last_frame = (q.frame == k_len - 6'h01);
  assign lmfc_hit = q.lmfc_s & ~q.lmfc_prev & ~q.test_lmfc[B_LMFC_MASK];
  assign adv      = ~q.out_valid | lane_ready;

  always_comb begin
    next_q = q;
    pop    = 1'b0;
    fifo_rev = {<<{fifo_data}};  // reference order for the flip check
    // pins pass two flops before use
    next_q.sync_meta = sync_n;
    next_q.sync_s    = q.sync_meta;
    next_q.lmfc_meta = lmfc_reset_req;
    next_q.lmfc_s    = q.lmfc_meta;
    next_q.lmfc_prev = q.lmfc_s;
    next_q.lanes     = lanes_for(q.sync_lane[F_FILT_LO +: 3], q.sync_lane[F_MODE_LO +: 3]);

    // bus: one wait cycle, then the answer edge where writes land
    next_q.waitrequest = 1'b1;
    if ((read | write) & q.waitrequest) begin
      next_q.waitrequest = 1'b0;
      unique case (idx)
        IDX_FRAMING: next_q.rdata = {24'h0, q.framing};
        IDX_SYNC:    next_q.rdata = {24'h0, q.sync_lane};
        IDX_TEST:    next_q.rdata = {24'h0, q.test_lmfc};
        IDX_STATUS:  next_q.rdata = {21'h0, sync_req, q.st, q.lanes};
        IDX_FRAMES:  next_q.rdata = {27'h0, q.frames};
        default:     next_q.rdata = 32'h0;
      endcase
    end
    if (write & ~q.waitrequest & byteenable[0]) begin
      unique case (idx)
        IDX_FRAMING: next_q.framing   = writedata[7:0] & MASK_FRAMING;
        IDX_SYNC:    next_q.sync_lane = writedata[7:0];
        IDX_TEST:    next_q.test_lmfc = writedata[7:0] & MASK_TEST;
        IDX_FRAMES:  next_q.frames    = writedata[4:0];
        default:     next_q.frames    = q.frames;
      endcase
    end

    // link word generator; a stalled receiver holds the word and backs up the fifo
    if (adv) begin
      next_q.out_valid = 1'b1;
      next_q.out_k     = 2'b00;
      if (sync_req) begin
        next_q.st       = ST_SYNC;
        next_q.out_data = {CH_K28_5, CH_K28_5};
        next_q.out_k    = 2'b11;
      end else if (pat == PAT_D21_5) begin
        next_q.out_data = {CH_D21_5, CH_D21_5};
      end else if (pat == PAT_K28_5) begin
        next_q.out_data = {CH_K28_5, CH_K28_5};
        next_q.out_k    = 2'b11;
      end else if (pat == PAT_RPAT) begin
        // disparity flip inverts every octet of the pattern
        next_q.out_data = {RPAT[q.rp], RPAT[q.rp + 4'h1]}
                        ^ {16{q.test_lmfc[B_RPAT_FLIP]}};
        next_q.rp       = (q.rp == RPAT_LAST) ? 4'h0 : q.rp + 4'h2;
      end else begin
        unique case (q.st)
          ST_SYNC: begin
            next_q.out_data = {CH_K28_5, CH_K28_5};
            next_q.out_k    = 2'b11;
            next_q.frame    = '0;
            next_q.mf       = '0;
            next_q.st       = q.framing[B_ILA_OFF] ? ST_DATA : ST_ILA;
          end
          ST_ILA: begin
            next_q.out_data = {2'b00, q.mf, 6'h00, q.frame};
            if (q.frame == '0) begin
              next_q.out_data[15:8] = CH_K28_0;
              next_q.out_k[1]       = 1'b1;
            end
            next_q.frame = q.frame + 6'h01;
            if (last_frame) begin
              next_q.out_data[7:0] = CH_K28_3;
              next_q.out_k[0]      = 1'b1;
              next_q.frame         = '0;
              next_q.mf            = q.mf + 2'h1;
              if (q.mf == ILA_LAST_MF && pat != PAT_ILA) begin
                next_q.st = ST_DATA;
              end
            end
          end
          ST_DATA: begin
            if (pat == PAT_ILA) begin
              next_q.st        = ST_ILA;
              next_q.frame     = '0;
              next_q.mf        = '0;
              next_q.out_valid = 1'b0;
            end else if (fifo_valid) begin
              pop             = 1'b1;
              next_q.out_data = fifo_data;
              if (q.framing[B_TRANSPORT]) begin
                next_q.out_data = {2'b00, q.frame, 2'b11, q.frame};
              end
              if (q.framing[B_FLIP]) begin
                next_q.out_data = {<<{next_q.out_data}};
              end
              if (last_frame && q.framing[B_LANE_AL]) begin
                next_q.out_data[7:0] = CH_K28_3;
                next_q.out_k[0]      = 1'b1;
              end else if (q.framing[B_FRAME_AL]) begin
                next_q.out_data[7:0] = CH_K28_7;
                next_q.out_k[0]      = 1'b1;
              end
              next_q.frame = last_frame ? 6'h00 : q.frame + 6'h01;
            end else begin
              next_q.out_valid = 1'b0;
            end
          end
          default: next_q.st = ST_SYNC;
        endcase
      end
    end
    if (lmfc_hit) begin
      next_q.frame = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= Q_RST;
    end else begin
      q <= next_q;
    end
  end

  a_k_default_five: assert property (@(posedge clk) disable iff (srst)
    !q.framing[B_CTRL_K] |-> k_len == 6'h05) else $error("default K is not five");
  a_k_from_reg: assert property (@(posedge clk) disable iff (srst)
    q.framing[B_CTRL_K] |-> k_len == {1'b0, q.frames} + 6'h01) else $error("K not from reg");
  a_sync_k28_5: assert property (@(posedge clk) disable iff (srst)
    (adv && q.sync_lane[B_SYNC_SEL] && q.sync_lane[B_SYNC_SW]) |=>
    (lane_data == 16'hBCBC && lane_k == 2'b11)) else $error("sync word not K28.5");
  a_ila_skipped: assert property (@(posedge clk) disable iff (srst)
    (adv && !sync_req && pat == PAT_NORMAL && q.st == ST_SYNC && q.framing[B_ILA_OFF])
    |=> q.st == ST_DATA) else $error("alignment sequence not skipped");
  a_ila_taken: assert property (@(posedge clk) disable iff (srst)
    (adv && !sync_req && pat == PAT_NORMAL && q.st == ST_SYNC && !q.framing[B_ILA_OFF])
    |=> q.st == ST_ILA) else $error("alignment sequence not started");
  a_flip_order: assert property (@(posedge clk) disable iff (srst)
    (pop && q.framing[B_FLIP] && !q.framing[B_TRANSPORT] && !q.framing[B_LANE_AL]
     && !q.framing[B_FRAME_AL]) |=> lane_data == $past(fifo_rev))
    else $error("data word not reversed");
  a_d21_pattern: assert property (@(posedge clk) disable iff (srst)
    (adv && !sync_req && pat == PAT_D21_5) |=> (lane_data == 16'hB5B5 && lane_k == 2'b00))
    else $error("D21.5 pattern wrong");
  a_lanes_bypass: assert property (@(posedge clk) disable iff (srst)
    (q.sync_lane[5:0] == 6'o01) |=> lane_enable == 8'hFF) else $error("bypass lanes wrong");
  a_lanes_real4x: assert property (@(posedge clk) disable iff (srst)
    (q.sync_lane[5:0] == 6'o42) |=> lane_enable == 8'h01) else $error("4X lanes wrong");
  a_lmfc_masked: assert property (@(posedge clk) disable iff (srst)
    (q.test_lmfc[B_LMFC_MASK] && !adv) |=> q.frame == $past(q.frame))
    else $error("masked lmfc reset taken");
  a_bus_answer: assert property (@(posedge clk) disable iff (srst)
    ((read || write) && waitrequest) |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not one cycle");
endmodule : serial_link_tx_control
`default_nettype wire

// >>> hdl/tx_link_pkg.sv
// constants and types shared by the serial link transmit control block
`default_nettype none
package tx_link_pkg;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned ADDR_W     = 5;
  // register indices; byte address is index times four
  localparam logic [2:0] IDX_FRAMING  = 3'h0;
  localparam logic [2:0] IDX_SYNC     = 3'h1;
  localparam logic [2:0] IDX_TEST     = 3'h2;
  localparam logic [2:0] IDX_STATUS   = 3'h4;
  localparam logic [2:0] IDX_FRAMES   = 3'h6;
  // reset values
  localparam logic [7:0] RST_FRAMING  = 8'h00;
  localparam logic [7:0] RST_SYNC     = 8'h01;
  localparam logic [7:0] RST_TEST     = 8'h00;
  localparam logic [4:0] RST_FRAMES   = 5'h08;
  // writable bits; the rest read as zero
  localparam logic [7:0] MASK_FRAMING = 8'h9F;
  localparam logic [7:0] MASK_TEST    = 8'hF8;
  // field positions
  localparam int unsigned B_CTRL_K    = 7;
  localparam int unsigned B_TRANSPORT = 4;
  localparam int unsigned B_FLIP      = 3;
  localparam int unsigned B_LANE_AL   = 2;
  localparam int unsigned B_FRAME_AL  = 1;
  localparam int unsigned B_ILA_OFF   = 0;
  localparam int unsigned B_SYNC_SW   = 7;
  localparam int unsigned B_SYNC_SEL  = 6;
  localparam int unsigned F_FILT_LO   = 3;
  localparam int unsigned F_MODE_LO   = 0;
  localparam int unsigned F_LINK_LO   = 5;
  localparam int unsigned B_RPAT_FLIP = 4;
  localparam int unsigned B_LMFC_MASK = 3;
  // framing
  localparam logic [5:0] K_DEFAULT    = 6'h05;
  localparam logic [1:0] ILA_LAST_MF  = 2'h3;
  localparam logic [7:0] CH_K28_5     = 8'hBC;
  localparam logic [7:0] CH_K28_3     = 8'h7C;
  localparam logic [7:0] CH_K28_7     = 8'hFC;
  localparam logic [7:0] CH_K28_0     = 8'h1C;
  localparam logic [7:0] CH_D21_5     = 8'hB5;
  localparam logic [0:11][7:0] RPAT   = {8'hBE, 8'hD7, 8'h23, 8'h47, 8'h6B, 8'h8F,
                                         8'hB3, 8'h14, 8'h5E, 8'hFB, 8'h35, 8'h59};
  localparam logic [3:0] RPAT_LAST    = 4'hA;
  // filter and lane codes
  localparam logic [2:0] FILT_BYPASS  = 3'h0;
  localparam logic [2:0] FILT_2X      = 3'h6;
  localparam logic [2:0] FILT_4X      = 3'h4;
  localparam logic [2:0] FILT_4X_IQ   = 3'h7;
  localparam logic [2:0] MODE_1       = 3'h1;
  localparam logic [2:0] MODE_2       = 3'h2;
  localparam logic [2:0] MODE_4       = 3'h4;
  typedef enum logic [1:0] {ST_SYNC = 2'b00, ST_ILA = 2'b01, ST_DATA = 2'b10} link_state_t;
  typedef enum logic [2:0] {
    PAT_NORMAL = 3'b000, PAT_D21_5 = 3'b001, PAT_K28_5 = 3'b010,
    PAT_ILA = 3'b011, PAT_RPAT = 3'b100
  } link_pat_t;
endpackage : tx_link_pkg
`default_nettype wire

// >>> test/link_receiver.sv
// link receiver model: takes link words, can hold off with ready low
`default_nettype none
module link_receiver (
  input  wire logic                          clk,
  input  wire logic                          srst,
  input  wire logic [tx_link_pkg::DATA_W-1:0] lane_data,
  input  wire logic [1:0]                    lane_k,
  input  wire logic                          lane_valid,
  output logic                               lane_ready,
  input  wire logic                          stall,
  output logic [tx_link_pkg::DATA_W-1:0]     got_data,
  output logic [1:0]                         got_k,
  output logic                               got_seen
);
  import tx_link_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ready is registered, so a stall takes hold one edge late, as in real logic
  always @(posedge clk) begin
    lane_ready <= !srst && !stall;
    got_seen   <= !srst && lane_valid && lane_ready; // got_seen stands one cycle per word
    if (lane_valid && lane_ready) begin
      got_data <= lane_data;
      got_k    <= lane_k;
    end
  end
endmodule : link_receiver
`default_nettype wire

// >>> test/serial_link_tx_control_tb.sv
// self-checking bench for the serial link transmit control block
`default_nettype none
module serial_link_tx_control_tb;
  import tx_link_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk, srst, read, write, waitrequest, sync_n, lmfc_reset_req;
  logic [ADDR_W-1:0] address;
  logic [31:0]       writedata, readdata;
  logic [3:0]        byteenable;
  logic [DATA_W-1:0] sample_data, lane_data, got_data;
  logic              sample_valid, sample_ready, lane_valid, lane_ready, stall, got_seen;
  logic [1:0]        lane_k, got_k;
  logic [7:0]        lane_enable;
  int                errors, total_checks;

  serial_link_tx_control i_dut (.clk(clk), .srst(srst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .sample_data(sample_data), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sync_n(sync_n), .lmfc_reset_req(lmfc_reset_req),
    .lane_data(lane_data), .lane_k(lane_k), .lane_valid(lane_valid),
    .lane_ready(lane_ready), .lane_enable(lane_enable));
  link_receiver i_rx (.clk(clk), .srst(srst), .lane_data(lane_data), .lane_k(lane_k),
    .lane_valid(lane_valid), .lane_ready(lane_ready), .stall(stall),
    .got_data(got_data), .got_k(got_k), .got_seen(got_seen));

  always #50 clk = ~clk;

  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask : chk

  task automatic fail_wait(input string what);
    $display("unexpected %s: expected answer seen none", what);
    errors++;
    final_report();
  endtask : fail_wait

  // one avalon access; the request holds until waitrequest is seen low
  task automatic bus(input logic wr, input logic [2:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd);
    int n = 0;
    @(posedge clk);
    address   <= {idx, 2'b00};
    writedata <= {24'h0, wd};
    read      <= !wr;
    write     <= wr;
    // waitrequest and readdata are read as they stood at the edge just passed
    do begin
      @(posedge clk);
      n++;
      if (n > 50)
        fail_wait("bus answer");
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wreg(input logic [2:0] idx, input logic [7:0] v);
    logic [31:0] rd;
    bus(1'b1, idx, v, rd);
  endtask : wreg

  task automatic rreg(input logic [2:0] idx, input logic [7:0] exp, input string what);
    logic [31:0] rd;
    bus(1'b0, idx, 8'h00, rd);
    chk(what, {24'h0, exp}, rd);
  endtask : rreg

  task automatic get_word;
    int n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > 200)
        fail_wait("link word");
    end while (got_seen !== 1'b1);
  endtask : get_word

  task automatic push(input logic [15:0] d);
    int n = 0;
    @(posedge clk);
    sample_data  <= d;
    sample_valid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (n > 50)
        fail_wait("sample push");
    end while (sample_ready !== 1'b1);
    sample_valid <= 1'b0;
  endtask : push

  // offer samples until ready stays low, counting the ones taken
  task automatic fill_fifo(output int cnt);
    int idle = 0;
    cnt = 0;
    @(posedge clk);
    sample_valid <= 1'b1;
    sample_data  <= 16'h1000;
    while (idle < 8 && cnt < 40) begin
      @(negedge clk);
      if (sample_ready === 1'b1) begin
        idle = 0;
        cnt++;
      end else
        idle++;
      @(posedge clk);
      sample_data <= 16'h1000 + cnt[15:0];
    end
    sample_valid <= 1'b0;
  endtask : fill_fifo

  // counts non-sync words until the link has been quiet for 20 cycles in total, counted without resetting
  task automatic drain(output int cnt);
    int idle = 0;
    cnt = 0;
    while (idle < 20 && cnt < 200) begin
      @(negedge clk);
      if (got_seen !== 1'b1)
        idle++;
      else if (got_data !== 16'hBCBC)
        cnt++;
    end
  endtask : drain

  task automatic check_regs;
    @(negedge clk);
    chk("lanes after reset", 32'hFF, lane_enable);
    rreg(IDX_FRAMING, 8'h00, "framing reset");
    rreg(IDX_SYNC, 8'h01, "lane config reset");
    rreg(IDX_TEST, 8'h00, "test reset");
    rreg(IDX_FRAMES, 8'h08, "frames reset");
    wreg(3'h3, 8'hFF);
    rreg(3'h3, 8'h00, "unmapped read");
    wreg(IDX_FRAMING, 8'hFF);
    rreg(IDX_FRAMING, 8'h9F, "framing reserved bits");
    wreg(IDX_TEST, 8'hFF);
    rreg(IDX_TEST, 8'hF8, "test reserved bits");
    wreg(IDX_TEST, 8'h00);
    wreg(IDX_FRAMING, 8'h00);
  endtask : check_regs

  task automatic check_lanes;
    logic [7:0] combo [10] = '{8'h04, 8'h02, 8'h01, 8'h39, 8'h31, 8'h32, 8'h21, 8'h3A,
                               8'h22, 8'h34};
    logic [7:0] lanes [10] = '{8'h0F, 8'h0F, 8'hFF, 8'h0F, 8'h0F, 8'h03, 8'h03, 8'h03,
                               8'h01, 8'h00};
    for (int i = 0; i < 10; i++) begin
      wreg(IDX_SYNC, combo[i]);
      repeat (2) @(negedge clk);
      chk("lane enable", {24'h0, lanes[i]}, lane_enable);
      rreg(IDX_SYNC, combo[i], "lane config readback");
    end
    wreg(IDX_SYNC, 8'h01);
  endtask : check_lanes

  task automatic check_sync_fill;
    int          cnt;
    logic [31:0] rd;
    wreg(IDX_SYNC, 8'hC1);
    get_word;
    chk("sync word", 32'h3BCBC, {got_k, got_data});
    bus(1'b0, IDX_STATUS, 8'h00, rd);
    chk("register sync", 32'h1, rd[10]);
    wreg(IDX_SYNC, 8'h41);
    @(posedge clk);
    sync_n <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b0, IDX_STATUS, 8'h00, rd);
    chk("pin ignored", 32'h0, rd[10]);
    wreg(IDX_SYNC, 8'hC1);
    @(posedge clk);
    sync_n <= 1'b1;
    stall  <= 1'b1;
    fill_fifo(cnt);
    chk("fifo depth", FIFO_DEPTH, cnt);
    wreg(IDX_FRAMING, 8'h01);
    wreg(IDX_SYNC, 8'h01);
    @(posedge clk);
    stall <= 1'b0;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      do get_word; while (got_data === 16'hBCBC);
      chk("word after sync release", 32'h1000 + i, got_data);
    end
    @(negedge clk);
    chk("ready after drain", 32'h1, sample_ready);
  endtask : check_sync_fill

  task automatic data_word(input logic [7:0] r0, input logic [15:0] s);
    wreg(IDX_FRAMING, r0);
    push(s);
    get_word;
  endtask : data_word

  task automatic check_data;
    int cnt;
    int marks = 0;
    data_word(8'h00, 16'h1234);
    chk("plain word", 32'h1234, got_data);
    data_word(8'h08, 16'h0001);
    chk("flipped word", 32'h8000, got_data);
    data_word(8'h02, 16'hA500);
    chk("frame marker", 32'h1A5FC, {got_k, got_data});
    data_word(8'h10, 16'h0000);
    chk("transport bits", 32'h3, {got_data[15:14], got_data[7:6]});
    wreg(IDX_FRAMING, 8'h04);
    @(posedge clk);
    stall <= 1'b1;
    fill_fifo(cnt);
    @(posedge clk);
    stall <= 1'b0;
    repeat (10) begin
      get_word;
      if (got_data[7:0] === 8'h7C && got_k[0] === 1'b1)
        marks++;
    end
    chk("lane markers in ten frames", 32'd2, marks);
    drain(cnt);
  endtask : check_data

  // stall across the release so that no alignment word slips past uncounted
  task automatic ila_count(input logic [7:0] r0, input int exp);
    int cnt;
    wreg(IDX_FRAMING, r0);
    wreg(IDX_SYNC, 8'hC1);
    repeat (4) get_word;
    @(posedge clk);
    stall <= 1'b1;
    wreg(IDX_SYNC, 8'h01);
    @(posedge clk);
    stall <= 1'b0;
    drain(cnt);
    chk("alignment words", exp, cnt);
  endtask : ila_count

  // a multiframe clock reset restarts the frame count unless masked; marker position shows it
  task automatic lmfc_run(input logic [7:0] r2, input int exp);
    int cnt;
    int pos = 0;
    wreg(IDX_TEST, r2);
    @(posedge clk);
    stall <= 1'b1;
    fill_fifo(cnt);
    lmfc_reset_req <= 1'b1;
    repeat (4) @(posedge clk);
    lmfc_reset_req <= 1'b0;
    repeat (4) @(posedge clk);
    stall <= 1'b0;
    do begin
      get_word;
      pos++;
    end while (pos < 8 && !(got_data[7:0] === 8'h7C && got_k[0] === 1'b1));
    chk("words to lane marker", exp, pos);
    drain(cnt);
  endtask : lmfc_run

  task automatic check_patterns;
    wreg(IDX_TEST, 8'h20);
    repeat (2) get_word;
    chk("d21.5 pattern", 32'h0B5B5, {got_k, got_data});
    wreg(IDX_TEST, 8'h40);
    // two words already in flight when the write lands still carry the old pattern
    repeat (3) get_word;
    chk("k28.5 pattern", 32'h3BCBC, {got_k, got_data});
    wreg(IDX_TEST, 8'h80);
    repeat (3) get_word;
    chk("rpat first word", 32'h0BED7, {got_k, got_data});
    get_word;
    chk("rpat second word", 32'h02347, {got_k, got_data});
    wreg(IDX_TEST, 8'h00);
  endtask : check_patterns

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    {read, write, sample_valid, stall, lmfc_reset_req} = '0;
    sync_n = 1'b1;
    address = '0;
    writedata = '0;
    byteenable = 4'hF;
    sample_data = '0;
    errors = 0;
    total_checks = 0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    check_regs;
    check_lanes;
    check_sync_fill;
    check_data;
    lmfc_run(8'h00, 6);
    lmfc_run(8'h08, 4);
    ila_count(8'h00, 20);
    wreg(IDX_FRAMES, 8'h03);
    ila_count(8'h80, 16);
    ila_count(8'h01, 0);
    check_patterns;
    final_report;
  end
endmodule : serial_link_tx_control_tb
`default_nettype wire
